// *** gpio_lcd_defs.vh ***
// Register offsets, reset values and segment-select codes for the dual GPIO port.
// Notes on behaviour
// - Each direction bit 1 makes its pin an output, 0 an input; reset 0.
// - Direction registers are write-only; reads return an undefined value.
// - Output latch is 8-bit read/write, resets to zero, drives output pins.
// - Readback bit with direction 1 returns the output latch bit.
// - Readback bit with direction 0 returns the sampled pin level.
// - Readback register is read-only; writes change nothing.
// - Port L pins are segments 17..24 under codes 0011 or 010X.
// - Port M pins are segments 25..32 under codes 001X or 010X.
// - Port M exists only in the larger variant and may be omitted.
// - Port M readback selects latch or pin by direction bit, like port L.
// - Port M direction reads undefined; writes configure each pin.
`ifndef GPIO_LCD_DEFS_VH
`define GPIO_LCD_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_L_DIR      12'h000
`define OFS_L_LATCH    12'h004
`define OFS_L_READBACK 12'h008
`define OFS_M_DIR      12'h00C
`define OFS_M_LATCH    12'h010
`define OFS_M_READBACK 12'h014
`define OFS_LCD_CTRL   12'h018

// ----------------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------------
`define RST_DIR        8'h00
`define RST_LATCH      8'h00
`define RST_SEG_SEL    4'h0
`define UNDEF_READ     8'h00
`define SEG_SEL_LSB    0
`define SEG_SEL_MSB    3

`endif

// *** pin_sync3.v ***
// Three-stage synchroniser bank with agreement filter for pin inputs.
`timescale 1ns/1ps
module pin_sync3 (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] pin_raw,
  output reg  [7:0] pin_level
);
  reg [7:0] s1_reg;
  reg [7:0] s2_reg;
  reg [7:0] s3_reg;
  genvar i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 8'h00;
      s2_reg <= 8'h00;
      s3_reg <= 8'h00;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once the second and third stages agree.
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_filt
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_level[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          pin_level[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

// *** gpio_port8.v ***
// One 8-bit port: direction, output latch, readback select and segment mux.
`timescale 1ns/1ps
`include "gpio_lcd_defs.vh"
module gpio_port8 (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       dir_we,
  input  wire       latch_we,
  input  wire [7:0] wdata,
  input  wire       seg_mode,
  input  wire [7:0] seg_in,
  input  wire [7:0] pin_in,
  output wire [7:0] latch_val,
  output wire [7:0] readback,
  output wire [7:0] pin_out_next,
  output wire [7:0] pin_oe_next
);
  reg  [7:0] dir_reg;
  reg  [7:0] latch_reg;
  wire [7:0] pin_level;

  pin_sync3 u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_raw   (pin_in),
    .pin_level (pin_level)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg   <= `RST_DIR;
      latch_reg <= `RST_LATCH;
    end else begin
      if (dir_we) begin
        dir_reg <= wdata;
      end
      if (latch_we) begin
        latch_reg <= wdata;
      end
    end
  end

  assign latch_val    = latch_reg;
  assign readback     = (dir_reg & latch_reg) | (~dir_reg & pin_level);
  // Segment mode overrides direction and data so the LCD owns the pin.
  assign pin_out_next = seg_mode ? seg_in : latch_reg;
  assign pin_oe_next  = seg_mode ? 8'hFF : dir_reg;
endmodule

// *** dual_gpio_lcd.v ***
// Top level: APB slave with ports L and M and their LCD segment pin sharing.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`include "gpio_lcd_defs.vh"
module dual_gpio_lcd #(
  parameter HAS_PORT_M = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [31:0] prdata,
  input  wire [7:0]  lcd_segment_outputs_low,
  input  wire [7:0]  lcd_segment_outputs_high,
  input  wire [7:0]  port_l_pin_in,
  output reg  [7:0]  port_l_pin_out,
  output reg  [7:0]  port_l_pin_oe,
  input  wire [7:0]  port_m_pin_in,
  output reg  [7:0]  port_m_pin_out,
  output reg  [7:0]  port_m_pin_oe,
  output reg  [3:0]  segment_select_field
);
  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // The slave answers in the access cycle with no wait states.
  wire        wr_acc = psel & penable & pwrite;
  wire        m_on   = (HAS_PORT_M != 0);
  reg         mapped;
  reg  [31:0] rdata_next;

  wire       l_dir_we   = wr_acc & (paddr == `OFS_L_DIR);
  wire       l_latch_we = wr_acc & (paddr == `OFS_L_LATCH);
  wire       m_dir_we   = wr_acc & m_on & (paddr == `OFS_M_DIR);
  wire       m_latch_we = wr_acc & m_on & (paddr == `OFS_M_LATCH);
  wire       ctrl_we    = wr_acc & (paddr == `OFS_LCD_CTRL);

  // --------------------------------------------------------------------------
  // Segment select decode
  // --------------------------------------------------------------------------
  wire [3:0] sgs    = segment_select_field;
  wire       l_seg  = (sgs == 4'h3) | (sgs[3:1] == 3'h2);
  wire       m_seg  = (sgs[3:1] == 3'h1) | (sgs[3:1] == 3'h2);

  wire [7:0] l_latch;
  wire [7:0] l_rb;
  wire [7:0] l_out_n;
  wire [7:0] l_oe_n;
  wire [7:0] m_latch;
  wire [7:0] m_rb;
  wire [7:0] m_out_n;
  wire [7:0] m_oe_n;

  gpio_port8 u_port_l (
    .pclk         (pclk),
    .presetn      (presetn),
    .dir_we       (l_dir_we),
    .latch_we     (l_latch_we),
    .wdata        (pwdata[7:0]),
    .seg_mode     (l_seg),
    .seg_in       (lcd_segment_outputs_low),
    .pin_in       (port_l_pin_in),
    .latch_val    (l_latch),
    .readback     (l_rb),
    .pin_out_next (l_out_n),
    .pin_oe_next  (l_oe_n)
  );

  gpio_port8 u_port_m (
    .pclk         (pclk),
    .presetn      (presetn),
    .dir_we       (m_dir_we),
    .latch_we     (m_latch_we),
    .wdata        (pwdata[7:0]),
    .seg_mode     (m_seg),
    .seg_in       (lcd_segment_outputs_high),
    .pin_in       (port_m_pin_in),
    .latch_val    (m_latch),
    .readback     (m_rb),
    .pin_out_next (m_out_n),
    .pin_oe_next  (m_oe_n)
  );

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    mapped     = 1'b1;
    case (paddr)
      `OFS_L_DIR:      rdata_next = {24'h000000, `UNDEF_READ};
      `OFS_L_LATCH:    rdata_next = {24'h000000, l_latch};
      `OFS_L_READBACK: rdata_next = {24'h000000, l_rb};
      `OFS_M_DIR: begin
        rdata_next = {24'h000000, `UNDEF_READ};
        mapped     = m_on;
      end
      `OFS_M_LATCH: begin
        rdata_next = m_on ? {24'h000000, m_latch} : 32'h00000000;
        mapped     = m_on;
      end
      `OFS_M_READBACK: begin
        rdata_next = m_on ? {24'h000000, m_rb} : 32'h00000000;
        mapped     = m_on;
      end
      `OFS_LCD_CTRL:   rdata_next = {28'h0000000, segment_select_field};
      default:         mapped = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  // Pins lag the registers by one cycle; that keeps every output on a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      segment_select_field <= `RST_SEG_SEL;
      port_l_pin_out       <= 8'h00;
      port_l_pin_oe        <= 8'h00;
      port_m_pin_out       <= 8'h00;
      port_m_pin_oe        <= 8'h00;
      prdata               <= 32'h00000000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      // Ready and error are decided in the setup cycle so both leave a flop.
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (ctrl_we) begin
        segment_select_field <= pwdata[`SEG_SEL_MSB:`SEG_SEL_LSB];
      end
      port_l_pin_out <= l_out_n;
      port_l_pin_oe  <= l_oe_n;
      port_m_pin_out <= m_on ? m_out_n : 8'h00;
      port_m_pin_oe  <= m_on ? m_oe_n : 8'h00;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rdata_next;
      end
    end
  end
endmodule

// *** gpio_monitor.sv ***
// Concurrent checks on the top level of the dual port block.
`timescale 1ns/1ps
module gpio_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire [7:0]  lcd_segment_outputs_low,
  input wire [7:0]  port_l_pin_out,
  input wire [7:0]  port_l_pin_oe,
  input wire [7:0]  port_m_pin_oe,
  input wire [3:0]  segment_select_field
);
  wire acc   = psel && penable;
  wire l_seg = segment_select_field inside {4'h3, 4'h4, 4'h5};
  wire m_seg = segment_select_field inside {[4'h2:4'h5]};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence dir_wr; acc && pwrite && paddr == 12'h000; endsequence
  sequence gpio_hold; !l_seg; endsequence
  ready_high_a: assert property (acc |-> pready) else $error("pready low");
  dir_to_oe_a: assert property (dir_wr ##1 gpio_hold |=> port_l_pin_oe == $past(pwdata[7:0], 2))
    else $error("oe does not follow direction write");
  l_seg_drive_a: assert property (l_seg |=> port_l_pin_oe == 8'hFF &&
    port_l_pin_out == $past(lcd_segment_outputs_low)) else $error("port L segment drive wrong");
  m_seg_drive_a: assert property (m_seg |=> port_m_pin_oe == 8'hFF)
    else $error("port M segment drive wrong");
  dir_read_a: assert property (acc && !pwrite && paddr inside {12'h000, 12'h00C} |-> prdata == 32'h0)
    else $error("direction read not fixed");
  ro_write_a: assert property (acc && pwrite && paddr == 12'h008 && !l_seg |=>
    $stable(port_l_pin_oe) && $stable(port_l_pin_out)) else $error("readback write changed pins");
  out_read_a: assert property (acc && !pwrite && paddr == 12'h008 && !l_seg |->
    ((prdata[7:0] ^ port_l_pin_out) & port_l_pin_oe) == 8'h00) else $error("output bit read wrong");
  reset_idle_a: assert property ($rose(presetn) |-> port_l_pin_oe == 8'h00)
    else $error("pins not inputs after reset");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr) else $error("no pslverr");
endmodule
bind dual_gpio_lcd gpio_monitor u_gpio_monitor (
  .pclk                    (pclk),
  .presetn                 (presetn),
  .psel                    (psel),
  .penable                 (penable),
  .pwrite                  (pwrite),
  .paddr                   (paddr),
  .pwdata                  (pwdata),
  .pready                  (pready),
  .pslverr                 (pslverr),
  .prdata                  (prdata),
  .lcd_segment_outputs_low (lcd_segment_outputs_low),
  .port_l_pin_out          (port_l_pin_out),
  .port_l_pin_oe           (port_l_pin_oe),
  .port_m_pin_oe           (port_m_pin_oe),
  .segment_select_field    (segment_select_field)
);

// *** pin_pad_model.sv ***
// Pad and segment driver model for one 8-bit port.
`timescale 1ns/1ps
module pin_pad_model (
  input  wire       pclk,
  input  wire [7:0] oe,
  input  wire [7:0] out,
  input  wire [7:0] ext,
  output reg  [7:0] seg,
  output wire [7:0] pin
);
  // The segment pattern moves every cycle so a stale copy cannot pass.
  initial seg = 8'h5A;
  always @(posedge pclk) seg <= seg + 8'h25;
  assign pin = (oe & out) | (~oe & ext);
endmodule

// *** tb_dual_gpio_port_lcd_segment_mux.sv ***
// Self-checking bench for the dual port block.
`timescale 1ns/1ps
`include "gpio_lcd_defs.vh"
module tb_dual_gpio_port_lcd_segment_mux;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  ext_l = 8'h00, ext_m = 8'h00, seg_l, seg_m, pin_l, pin_m, l_out, l_oe, m_out, m_oe;
  logic [3:0]  ssf;
  integer      fails = 0, checked = 0, c;
  always #5 pclk = ~pclk;
  pin_pad_model u_pad_l (.pclk(pclk), .oe(l_oe), .out(l_out), .ext(ext_l), .seg(seg_l), .pin(pin_l));
  pin_pad_model u_pad_m (.pclk(pclk), .oe(m_oe), .out(m_out), .ext(ext_m), .seg(seg_m), .pin(pin_m));
  dual_gpio_lcd u_dual_gpio_lcd (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .lcd_segment_outputs_low(seg_l), .lcd_segment_outputs_high(seg_m),
    .port_l_pin_in(pin_l), .port_l_pin_out(l_out), .port_l_pin_oe(l_oe), .port_m_pin_in(pin_m),
    .port_m_pin_out(m_out), .port_m_pin_oe(m_oe), .segment_select_field(ssf));
  task results;
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    integer n;
    begin
      n = 0;
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin n++; @(posedge pclk); end
      if (n == 50) fails++;
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask
  task t_port(input logic p, input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] ex);
    logic [11:0] b;
    begin
      b = p ? 12'h00C : 12'h000;
      if (p) ext_m <= ex; else ext_l <= ex;
      apb(0, b + 12'h004, 8'h00); chk(rd, 32'h0);
      apb(1, b, dir); apb(1, b + 12'h004, dat);
      repeat (5) @(posedge pclk);
      chk(p ? m_oe : l_oe, {24'h0, dir});
      chk(p ? m_out : l_out, {24'h0, dat});
      apb(0, b + 12'h008, 8'h00); chk(rd, {24'h0, (dat & dir) | (ex & ~dir)});
      apb(0, b + 12'h004, 8'h00); chk(rd, {24'h0, dat});
      apb(0, b, 8'h00); chk(rd, {24'h0, `UNDEF_READ});
    end
  endtask
  task t_ro;
    apb(1, 12'h008, 8'hFF); apb(0, 12'h004, 8'h00); chk(rd, 32'h3C);
    apb(1, 12'h01C, 8'h01); chk(er, 1'b1);
  endtask
  task t_seg;
    for (c = 0; c < 16; c++) begin
      apb(1, 12'h018, c[7:0]); @(posedge pclk);
      chk(ssf, c[3:0]);
      chk(l_out, (c >= 3 && c <= 5) ? {24'h0, seg_l - 8'h25} : 32'h3C);
      chk(m_out, (c >= 2 && c <= 5) ? {24'h0, seg_m - 8'h25} : 32'hC3);
      chk(l_oe, (c >= 3 && c <= 5) ? 32'hFF : 32'hA5);
      chk(m_oe, (c >= 2 && c <= 5) ? 32'hFF : 32'h5A);
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk(l_oe, 32'h0);
    t_port(0, 8'hA5, 8'h3C, 8'h96);
    t_port(1, 8'h5A, 8'hC3, 8'h69);
    t_ro;
    t_seg;
    results;
  end
  initial begin
    #100000;
    fails++;
    results;
  end
endmodule
